// ==== rtl/e1_line_control_regs.sv ====
// two common control registers of one e1 channel and the line controls
// assumes inputs synchronous to ref_clk_i and a host that strobes one cycle
// elastic store commands assume a running backplane clock
`default_nettype none

module e1_line_control_regs
    import e1_line_control_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    // host port
    input  wire host_req_t  host_req_i,
    output var  logic [7:0] host_rdata_o,
    output var  logic       host_rvalid_o,
    // loopback bit held in the neighbouring control register
    input  wire logic       local_loop_enable_i,
    input  wire logic       tx_sync_signal_sel_i,
    // transmit formatter data and bit strobe
    input  wire line_pair_t tx_data_i,
    input  wire logic       tx_bit_strobe_i,
    // receive line pair
    input  wire line_pair_t rx_line_i,
    // elastic store state, valid while backplane clock runs
    input  wire logic [8:0] rx_store_separation_i,
    // receive timeslot stream
    input  wire logic [4:0] rx_timeslot_i,
    input  wire logic [7:0] rx_slot_data_i,
    input  wire logic       rx_slot_valid_i,
    // outputs
    output var  line_pair_t tx_line_o,
    output var  logic       line_open_drain_sel_o,
    output var  line_pair_t jitter_atten_in_o,
    output var  logic       line_iface_reset_o,
    output var  logic       rx_store_align_o,
    output var  logic       rx_store_reset_o,
    output var  logic [8:0] rx_store_depth_o,
    output var  logic [4:0] rx_monitor_chan_o,
    output var  logic [7:0] rx_monitor_data_reg_o,
    output var  logic       tx_g703_o,
    output var  logic       rx_g703_o,
    output var  logic       rx_termination_sel_o,
    output var  logic [1:0] tx_prn_mode_o,
    output var  logic [1:0] rx_prn_mode_o
);

    // ========================================================================
    // helpers
    function automatic logic rising_write(
        input logic [7:0] old_val,
        input logic [7:0] new_val,
        input int unsigned bit_pos
    );
        rising_write = !old_val[bit_pos] && new_val[bit_pos];
    endfunction : rising_write

    function automatic sync_mode_t sync_decode(
        input logic sync_en,
        input logic tx_sel
    );
        case ({sync_en, tx_sel})
            2'b00:   sync_decode = SYNC_NORMAL_BOTH;
            2'b01:   sync_decode = SYNC_TX_ONLY;
            2'b10:   sync_decode = SYNC_BOTH;
            default: sync_decode = SYNC_RX_ONLY;
        endcase
    endfunction : sync_decode

    // ========================================================================
    // address decode
    logic       wr_ctrl_a;
    logic       wr_ctrl_b;
    logic [7:0] line_loopback_store_control;
    logic [7:0] line_driver_prbs_control;

    assign wr_ctrl_a = host_req_i.wr
        && (host_req_i.addr == LINE_LOOPBACK_STORE_CONTROL_ADDR);
    assign wr_ctrl_b = host_req_i.wr
        && (host_req_i.addr == LINE_DRIVER_PRBS_CONTROL_ADDR);

    // ========================================================================
    // register storage
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            line_loopback_store_control <= LINE_LOOPBACK_STORE_CONTROL_RST;
        end else if (wr_ctrl_a) begin
            line_loopback_store_control <= host_req_i.wdata;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            line_driver_prbs_control <= LINE_DRIVER_PRBS_CONTROL_RST;
        end else if (wr_ctrl_b) begin
            line_driver_prbs_control <= host_req_i.wdata;
        end
    end

    // ========================================================================
    // read port
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            host_rvalid_o <= 1'b0;
        end else begin
            host_rvalid_o <= host_req_i.rd;
        end
    end

    // read data stands for the one cycle that rvalid is high
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            host_rdata_o <= UNMAPPED_READ_VALUE;
        end else begin
            if (!host_req_i.rd) begin
                host_rdata_o <= UNMAPPED_READ_VALUE;
            end else begin
                case (host_req_i.addr)
                    LINE_LOOPBACK_STORE_CONTROL_ADDR: begin
                        host_rdata_o <= line_loopback_store_control;
                    end
                    LINE_DRIVER_PRBS_CONTROL_ADDR: begin
                        host_rdata_o <= line_driver_prbs_control;
                    end
                    default: begin
                        host_rdata_o <= UNMAPPED_READ_VALUE;
                    end
                endcase
            end
        end
    end

    // ========================================================================
    // write-edge decode
    logic line_iface_rise;
    logic store_align_rise;
    logic store_reset_rise;
    logic separation_short;

    assign line_iface_rise = wr_ctrl_a && rising_write(
        line_loopback_store_control, host_req_i.wdata,
        LINE_IFACE_RESET_BIT);
    assign store_align_rise = wr_ctrl_a && rising_write(
        line_loopback_store_control, host_req_i.wdata,
        RX_STORE_ALIGN_BIT);
    assign store_reset_rise = wr_ctrl_a && rising_write(
        line_loopback_store_control, host_req_i.wdata,
        RX_STORE_RESET_BIT);
    // pointers already half a frame apart are left alone
    assign separation_short =
        (rx_store_separation_i < HALF_FRAME_BITS);

    // ========================================================================
    // write-edge actions
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            line_iface_reset_o <= 1'b0;
        end else begin
            line_iface_reset_o <= line_iface_rise;
        end
    end

    // host is expected to write these only with the backplane clock stable
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rx_store_align_o <= 1'b0;
        end else begin
            rx_store_align_o <= store_align_rise
                && separation_short;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rx_store_reset_o <= 1'b0;
        end else begin
            rx_store_reset_o <= store_reset_rise;
        end
    end

    // target pointer separation that goes with each store command
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rx_store_depth_o <= FRAME_BITS;
        end else if (store_reset_rise) begin
            rx_store_depth_o <= FRAME_BITS;
        end else if (store_align_rise && separation_short) begin
            rx_store_depth_o <= HALF_FRAME_BITS;
        end
    end

    // ========================================================================
    // receive channel monitor
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rx_monitor_data_reg_o <= MONITOR_DATA_RST;
        end else if (rx_slot_valid_i && (rx_timeslot_i ==
                     line_loopback_store_control[RX_MONITOR_CHAN_MSB:
                                                 RX_MONITOR_CHAN_LSB])) begin
            rx_monitor_data_reg_o <= rx_slot_data_i;
        end
    end

    // ========================================================================
    // disconnect pattern generator
    logic pattern_bit;
    logic mark_polarity;
    logic pattern_sel;

    assign pattern_sel = line_driver_prbs_control[DISCONNECT_PATTERN_GEN_BIT];

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pattern_bit <= 1'b1;
        end else if (tx_bit_strobe_i) begin
            pattern_bit <= !pattern_bit;
        end
    end

    // marks alternate polarity, spaces leave the line idle
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            mark_polarity <= 1'b0;
        end else if (tx_bit_strobe_i && pattern_bit) begin
            mark_polarity <= !mark_polarity;
        end
    end

    // ========================================================================
    // line transmit and receive paths
    // the driver shows the pattern or the formatter data
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            tx_line_o <= '0;
        end else if (pattern_sel) begin
            tx_line_o.pos <= pattern_bit && !mark_polarity;
            tx_line_o.neg <= pattern_bit && mark_polarity;
        end else begin
            tx_line_o <= tx_data_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            jitter_atten_in_o <= '0;
        end else if (local_loop_enable_i) begin
            jitter_atten_in_o <= tx_data_i;
        end else begin
            jitter_atten_in_o <= rx_line_i;
        end
    end

    // ========================================================================
    // static line options
    sync_mode_t sync_mode;

    assign sync_mode = sync_decode(
        line_driver_prbs_control[SYNC_IFACE_ENABLE_BIT],
        tx_sync_signal_sel_i);

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            tx_g703_o <= 1'b0;
        end else begin
            tx_g703_o <= (sync_mode == SYNC_TX_ONLY)
                      || (sync_mode == SYNC_BOTH);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rx_g703_o <= 1'b0;
        end else begin
            rx_g703_o <= (sync_mode == SYNC_RX_ONLY)
                      || (sync_mode == SYNC_BOTH);
        end
    end

    // levels follow the registers one cycle later
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            line_open_drain_sel_o <= 1'b0;
        end else begin
            line_open_drain_sel_o <=
                line_driver_prbs_control[LINE_OPEN_DRAIN_SEL_BIT];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rx_termination_sel_o <= 1'b0;
        end else begin
            rx_termination_sel_o <=
                line_driver_prbs_control[RX_TERMINATION_SEL_BIT];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            tx_prn_mode_o <= '0;
        end else begin
            tx_prn_mode_o <= line_driver_prbs_control[TX_PRN_MODE_HI:
                TX_PRN_MODE_LO];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rx_prn_mode_o <= '0;
        end else begin
            rx_prn_mode_o <= line_driver_prbs_control[RX_PRN_MODE_HI:
                RX_PRN_MODE_LO];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rx_monitor_chan_o <= '0;
        end else begin
            rx_monitor_chan_o <= line_loopback_store_control[
                RX_MONITOR_CHAN_MSB:RX_MONITOR_CHAN_LSB];
        end
    end

endmodule : e1_line_control_regs

`default_nettype wire

// ==== rtl/e1_line_control_pkg.sv ====
// constants and carrier types for the e1 line control register pair
// assumes one 250 MHz clock and an 8-bit synchronous host port
`default_nettype none

package e1_line_control_pkg;

    // ========================================================================
    // host port geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // ========================================================================
    // register addresses
    localparam logic [7:0] LINE_LOOPBACK_STORE_CONTROL_ADDR = 8'h15;
    localparam logic [7:0] LINE_DRIVER_PRBS_CONTROL_ADDR    = 8'h16;

    // ========================================================================
    // reset values
    localparam logic [7:0] LINE_LOOPBACK_STORE_CONTROL_RST = 8'h00;
    localparam logic [7:0] LINE_DRIVER_PRBS_CONTROL_RST    = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE             = 8'h00;
    localparam logic [7:0] MONITOR_DATA_RST                = 8'h00;

    // ========================================================================
    // fields of the first control register
    localparam int unsigned LINE_IFACE_RESET_BIT = 7;
    localparam int unsigned RX_STORE_ALIGN_BIT   = 6;
    localparam int unsigned RX_STORE_RESET_BIT   = 5;
    localparam int unsigned RX_MONITOR_CHAN_MSB  = 4;
    localparam int unsigned RX_MONITOR_CHAN_LSB  = 0;

    // ========================================================================
    // fields of the second control register
    localparam int unsigned LINE_OPEN_DRAIN_SEL_BIT    = 7;
    localparam int unsigned DISCONNECT_PATTERN_GEN_BIT = 6;
    localparam int unsigned SYNC_IFACE_ENABLE_BIT      = 5;
    localparam int unsigned RX_TERMINATION_SEL_BIT     = 4;
    localparam int unsigned TX_PRN_MODE_HI             = 3;
    localparam int unsigned TX_PRN_MODE_LO             = 2;
    localparam int unsigned RX_PRN_MODE_HI             = 1;
    localparam int unsigned RX_PRN_MODE_LO             = 0;

    // ========================================================================
    // elastic store geometry, separation counted in bits
    localparam int unsigned SEP_W              = 9;
    localparam logic [8:0]  FRAME_BITS         = 9'h100;
    localparam logic [8:0]  HALF_FRAME_BITS    = 9'h080;

    // ========================================================================
    // carrier types
    typedef struct packed {
        logic pos;
        logic neg;
    } line_pair_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    typedef enum logic [1:0] {
        SYNC_NORMAL_BOTH,
        SYNC_TX_ONLY,
        SYNC_BOTH,
        SYNC_RX_ONLY
    } sync_mode_t;

endpackage : e1_line_control_pkg

`default_nettype wire

// ==== tb/e1_line_control_regs_chk.sv ====
// checker for the e1 line control register pair
// assumes a bind onto e1_line_control_regs, one clock domain
`default_nettype none
module e1_line_control_regs_chk
    import e1_line_control_pkg::*;
(
    input wire logic       ref_clk_i,
    input wire logic       rst_n_i,
    input wire host_req_t  host_req_i,
    input wire logic [7:0] host_rdata_o,
    input wire logic       host_rvalid_o,
    input wire logic       local_loop_enable_i,
    input wire line_pair_t tx_data_i,
    input wire line_pair_t rx_line_i,
    input wire logic [8:0] rx_store_separation_i,
    input wire line_pair_t jitter_atten_in_o,
    input wire logic       line_iface_reset_o,
    input wire logic       rx_store_align_o,
    input wire logic       rx_store_reset_o,
    input wire logic [8:0] rx_store_depth_o,
    input wire logic [4:0] rx_monitor_chan_o,
    input wire logic       line_open_drain_sel_o,
    input wire logic       rx_termination_sel_o,
    input wire logic [1:0] tx_prn_mode_o,
    input wire logic [1:0] rx_prn_mode_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ====
    // shadow registers
    logic [7:0] r15, r16, p15, p16, rd_exp;
    logic       w15, lir_up, ali_up, rsr_up, low_sep;
    assign w15    = host_req_i.wr && host_req_i.addr == 8'h15;
    assign lir_up = w15 && host_req_i.wdata[7] && !r15[7];
    assign ali_up = w15 && host_req_i.wdata[6] && !r15[6];
    assign rsr_up = w15 && host_req_i.wdata[5] && !r15[5];
    assign low_sep = rx_store_separation_i < HALF_FRAME_BITS;
    assign rd_exp = host_req_i.addr == 8'h15 ? r15 :
                    host_req_i.addr == 8'h16 ? r16 : 8'h00;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            r15 <= 8'h00;
            r16 <= 8'h00;
        end else if (host_req_i.wr) begin
            if (host_req_i.addr == 8'h15) r15 <= host_req_i.wdata;
            if (host_req_i.addr == 8'h16) r16 <= host_req_i.wdata;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        p15 <= rst_n_i ? r15 : 8'h00;
        p16 <= rst_n_i ? r16 : 8'h00;
    end
    // ====
    // assertions
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_read_answer: assert property (host_req_i.rd |=> host_rvalid_o
        && host_rdata_o == $past(rd_exp)) else $error("read answer wrong");
    a_line_reset: assert property ($past(rst_n_i) |->
        line_iface_reset_o == $past(lir_up)) else $error("line reset pulse");
    a_store_reset: assert property (rsr_up |=> rx_store_reset_o
        && rx_store_depth_o == FRAME_BITS) else $error("store reset");
    a_align_run: assert property (ali_up && low_sep && !rsr_up |=>
        rx_store_align_o && rx_store_depth_o == HALF_FRAME_BITS)
        else $error("align not done");
    a_align_skip: assert property (ali_up && !low_sep && !rsr_up |=>
        !rx_store_align_o && $stable(rx_store_depth_o)) else $error("align ran");
    a_loop_source: assert property ($past(rst_n_i) |-> jitter_atten_in_o ==
        ($past(local_loop_enable_i) ? $past(tx_data_i) : $past(rx_line_i)))
        else $error("attenuator source wrong");
    a_monitor_chan: assert property (rx_monitor_chan_o == p15[4:0])
        else $error("monitor channel wrong");
    a_driver_fields: assert property ({line_open_drain_sel_o,
        rx_termination_sel_o, tx_prn_mode_o, rx_prn_mode_o} ==
        {p16[7], p16[4], p16[3:0]}) else $error("line fields wrong");
    c_line_reset: cover property (lir_up);
    c_align: cover property (ali_up && low_sep);
    c_store_reset: cover property (rsr_up);
endmodule : e1_line_control_regs_chk
`default_nettype wire

// ==== tb/e1_host_model.sv ====
// host processor model driving the register port
// assumes ref_clk_i of the register block, backplane clock running
`default_nettype none
module e1_host_model
    import e1_line_control_pkg::*;
(
    input  wire logic       ref_clk_i,
    output var  host_req_t  host_req_o,
    input  wire logic [7:0] host_rdata_i,
    input  wire logic       host_rvalid_i
);
    timeunit 1ns;
    timeprecision 100ps;
    initial host_req_o = '0;
    // one strobe, released after the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        #1 host_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk_i);
        #1 host_req_o = '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic v);
        @(posedge ref_clk_i);
        #1 host_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk_i);
        #1 host_req_o = '0;
        d = host_rdata_i;
        v = host_rvalid_i;
    endtask : rd
endmodule : e1_host_model
`default_nettype wire

// ==== tb/e1_line_control_regs_tb.sv ====
// self-checking bench for the e1 line control register pair
// assumes the checker and host model files compiled before it
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    num_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module e1_line_control_regs_tb
    import e1_line_control_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic       ref_clk_i, rst_n_i, host_rvalid_o, local_loop_enable_i, vv;
    logic       tx_sync_signal_sel_i, tx_bit_strobe_i, rx_slot_valid_i;
    logic       line_open_drain_sel_o, line_iface_reset_o, rx_store_align_o;
    logic       rx_store_reset_o, tx_g703_o, rx_g703_o, rx_termination_sel_o;
    logic [7:0] host_rdata_o, rx_slot_data_i, rx_monitor_data_reg_o, rv;
    logic [8:0] rx_store_separation_i, rx_store_depth_o;
    logic [4:0] rx_timeslot_i, rx_monitor_chan_o;
    logic [1:0] tx_prn_mode_o, rx_prn_mode_o;
    host_req_t  host_req_i;
    line_pair_t tx_data_i, rx_line_i, tx_line_o, jitter_atten_in_o;
    int         num_errors = 0;
    int         cmp_count = 0;
    e1_line_control_regs e1_line_control_regs_inst (.ref_clk_i, .rst_n_i,
        .host_req_i, .host_rdata_o, .host_rvalid_o, .local_loop_enable_i,
        .tx_sync_signal_sel_i, .tx_data_i, .tx_bit_strobe_i, .rx_line_i,
        .rx_store_separation_i, .rx_timeslot_i, .rx_slot_data_i,
        .rx_slot_valid_i, .tx_line_o, .line_open_drain_sel_o,
        .jitter_atten_in_o, .line_iface_reset_o, .rx_store_align_o,
        .rx_store_reset_o, .rx_store_depth_o, .rx_monitor_chan_o,
        .rx_monitor_data_reg_o, .tx_g703_o, .rx_g703_o, .rx_termination_sel_o,
        .tx_prn_mode_o, .rx_prn_mode_o);
    e1_host_model e1_host_model_inst (.ref_clk_i, .host_req_o(host_req_i),
        .host_rdata_i(host_rdata_o), .host_rvalid_i(host_rvalid_o));
    // ====
    // helpers
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        e1_host_model_inst.wr(a, d);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        e1_host_model_inst.rd(a, rv, vv);
        `CHK("rvalid", 1'b1, vv)
        `CHK("rdata", e, rv)
    endtask : rd_chk
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    // ====
    // scenarios
    task automatic t_reset_map;
        wr(8'h14, 8'hff);
        rd_chk(8'h15, LINE_LOOPBACK_STORE_CONTROL_RST);
        rd_chk(8'h16, LINE_DRIVER_PRBS_CONTROL_RST);
        rd_chk(8'h17, UNMAPPED_READ_VALUE);
        `CHK("depth", FRAME_BITS, rx_store_depth_o)
        $display("test reset_map done");
    endtask : t_reset_map
    task automatic t_line_reset;
        wr(8'h15, 8'h80);
        `CHK("lir pulse", 1'b1, line_iface_reset_o)
        step(1);
        `CHK("lir end", 1'b0, line_iface_reset_o)
        wr(8'h15, 8'h80);
        `CHK("lir again", 1'b0, line_iface_reset_o)
        wr(8'h15, 8'h00);
        wr(8'h15, 8'h80);
        `CHK("lir rearm", 1'b1, line_iface_reset_o)
        $display("test line_reset done");
    endtask : t_line_reset
    task automatic t_store;
        rx_store_separation_i = 9'h07f;
        wr(8'h15, 8'h40);
        `CHK("align", 1'b1, rx_store_align_o)
        `CHK("depth half", HALF_FRAME_BITS, rx_store_depth_o)
        wr(8'h15, 8'h20);
        `CHK("sreset", 1'b1, rx_store_reset_o)
        `CHK("depth frame", FRAME_BITS, rx_store_depth_o)
        rx_store_separation_i = HALF_FRAME_BITS;
        wr(8'h15, 8'h40);
        `CHK("no align", 1'b0, rx_store_align_o)
        `CHK("depth kept", FRAME_BITS, rx_store_depth_o)
        $display("test store done");
    endtask : t_store
    task automatic t_monitor;
        wr(8'h15, 8'h1f);
        step(1);
        `CHK("chan", 5'h1f, rx_monitor_chan_o)
        rx_timeslot_i = 5'h1f;
        rx_slot_data_i = 8'ha5;
        rx_slot_valid_i = 1'b1;
        step(1);
        rx_timeslot_i = 5'h1e;
        rx_slot_data_i = 8'h3c;
        step(1);
        rx_slot_valid_i = 1'b0;
        step(1);
        `CHK("monitor", 8'ha5, rx_monitor_data_reg_o)
        $display("test monitor done");
    endtask : t_monitor
    task automatic t_fields;
        logic [7:0] v [4] = '{8'h9c, 8'h23, 8'h3a, 8'h05};
        logic [7:0] w;
        for (int i = 0; i < 8; i++) begin
            w = v[i/2];
            tx_sync_signal_sel_i = i[0];
            wr(8'h16, w);
            step(2);
            rd_chk(8'h16, w);
            `CHK("open drain", w[7], line_open_drain_sel_o)
            `CHK("term", w[4], rx_termination_sel_o)
            `CHK("tx prn", w[3:2], tx_prn_mode_o)
            `CHK("rx prn", w[1:0], rx_prn_mode_o)
            `CHK("tx g703", w[5] ^ i[0], tx_g703_o)
            `CHK("rx g703", w[5], rx_g703_o)
        end
        $display("test fields done");
    endtask : t_fields
    task automatic t_loopback;
        wr(8'h16, 8'h00);
        tx_data_i = 2'b10;
        rx_line_i = 2'b01;
        step(2);
        `CHK("atten rx", 2'b01, jitter_atten_in_o)
        local_loop_enable_i = 1'b1;
        step(2);
        `CHK("atten loop", 2'b10, jitter_atten_in_o)
        `CHK("tx line", 2'b10, tx_line_o)
        $display("test loopback done");
    endtask : t_loopback
    task automatic t_pattern;
        logic [1:0] exp_line [4] = '{2'b10, 2'b00, 2'b01, 2'b00};
        wr(8'h16, 8'h40);
        step(1);
        for (int k = 0; k < 4; k++) begin
            `CHK("pattern", exp_line[k], tx_line_o)
            tx_bit_strobe_i = 1'b1;
            step(1);
            tx_bit_strobe_i = 1'b0;
            step(1);
        end
        wr(8'h16, 8'h00);
        step(1);
        `CHK("normal data", 2'b10, tx_line_o)
        $display("test pattern done");
    endtask : t_pattern
    // ====
    // clock, reset, sequence, watchdog
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        {rst_n_i, local_loop_enable_i, tx_sync_signal_sel_i} = 3'h0;
        {tx_bit_strobe_i, rx_slot_valid_i, rx_slot_data_i} = 10'h000;
        {rx_store_separation_i, rx_timeslot_i} = 14'h0000;
        {tx_data_i, rx_line_i} = 4'h0;
        repeat (6) @(posedge ref_clk_i);
        #1 rst_n_i = 1'b1;
        t_reset_map;
        t_line_reset;
        t_store;
        t_monitor;
        t_fields;
        t_loopback;
        t_pattern;
        print_verdict;
    end
    initial begin
        #20000;
        num_errors++;
        print_verdict;
    end
endmodule : e1_line_control_regs_tb
bind e1_line_control_regs e1_line_control_regs_chk e1_line_control_regs_chk_inst (
    .ref_clk_i, .rst_n_i, .host_req_i, .host_rdata_o, .host_rvalid_o,
    .local_loop_enable_i, .tx_data_i, .rx_line_i, .rx_store_separation_i,
    .jitter_atten_in_o, .line_iface_reset_o, .rx_store_align_o,
    .rx_store_reset_o, .rx_store_depth_o, .rx_monitor_chan_o,
    .line_open_drain_sel_o, .rx_termination_sel_o, .tx_prn_mode_o,
    .rx_prn_mode_o);
`default_nettype wire
